// >>> core/tag_i2c_slave_host_port.sv
// two-wire target port of the tag: protocol engine and register file
`timescale 1ns/1ps
`default_nettype none
module tag_i2c_slave_host_port
  import tag_i2c_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // bus pins
  input  wire logic        select_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_oe_n,
  // configuration and power
  input  wire logic [7:0]  nv_config_byte_zero,
  input  wire logic        interface_supply_pin,
  // events and interrupt line
  input  wire logic        irq_pending,
  output logic             irq,
  // buffer side
  output write_type        buf_wr,
  output logic             buf_rd,
  input  wire logic [7:0]  buf_rdata,
  // eeprom side
  output ee_req_type       ee_req,
  output logic [6:0]       ee_rd_block,
  input  wire logic [31:0] ee_rdata,
  // direct command side
  output logic             cmd_strobe,
  output logic [5:0]       command_code_bits,
  input  wire logic        cmd_reject
);
  logic          sel_n;
  logic          scl;
  logic          sda;
  logic          scl_d;
  logic          sda_d;
  bus_state_type state;
  logic [7:0]    shreg;
  logic [2:0]    bit_cnt;
  logic [2:0]    byte_idx;
  logic          is_read;
  logic [1:0]    mode;
  logic [6:0]    ptr;
  logic [1:0]    ee_byte;
  logic [31:0]   ee_data;
  logic [7:0]    tx_byte;
  logic [7:0]    regs [reg_count];

  pin_sync u_sel (.core_clk(core_clk), .srst(srst), .pin(select_n), .level(sel_n));
  pin_sync u_scl (.core_clk(core_clk), .srst(srst), .pin(scl_in), .level(scl));
  pin_sync u_sda (.core_clk(core_clk), .srst(srst), .pin(sda_in), .level(sda));

  // bus edges on the filtered levels; filtering keeps fast-plus timing [RL2]
  wire scl_rise   = scl & ~scl_d;
  wire scl_fall   = ~scl & scl_d;
  wire start_cond = scl & scl_d & sda_d & ~sda;
  wire stop_cond  = scl & scl_d & ~sda_d & sda;
  wire enabled    = ~sel_n;                                  // [RL3]
  wire [6:0] own_addr = {addr_fixed_bits, nv_config_byte_zero[addr_low_lsb +: 3]}; // [RL7] [RL8]
  wire byte_done  = scl_rise && bit_cnt == 3'h7;
  wire [7:0] rx_byte = {shreg[6:0], sda};
  wire addr_hit   = shreg[7:1] == own_addr;                  // [RL1]
  wire restricted = interface_supply_pin;
  wire mode_ok    = ~restricted || shreg[7:6] == mode_reg
                    || shreg[7:6] == mode_eeprom;            // [RL6]
  wire reg_ok     = ptr < 7'(reg_count);
  wire [7:0] reg_rd = reg_ok ? regs[ptr[4:0]] : 8'h00;      // [RL14]
  wire [7:0] ee_rd_byte = ee_rdata[8'(3 - ee_byte) * 8 +: 8];

  function automatic logic [7:0] read_byte(input logic [1:0] m, input logic rej,
                                           input logic [7:0] r, input logic [7:0] b,
                                           input logic [7:0] e);
    case (m)
      mode_reg:     read_byte = r;
      mode_eeprom:  read_byte = e;
      mode_buffer:  read_byte = b;
      default:      read_byte = rej ? cmd_reject_answer : cmd_ok_answer; // [RL18]
    endcase
  endfunction : read_byte

  wire [7:0] next_tx = read_byte(mode, cmd_reject, reg_rd, buf_rdata, ee_rd_byte);

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  // protocol engine; bits sampled on scl rise, sda driven after scl fall
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state      <= st_idle;
      shreg      <= 8'h00;
      bit_cnt    <= 3'h0;
      byte_idx   <= 3'h0;
      is_read    <= 1'b0;
      mode       <= mode_reg;
      ptr        <= 7'h00;
      ee_byte    <= 2'h0;
      ee_data    <= 32'h0;
      tx_byte    <= 8'h00;
      sda_oe_n   <= 1'b1;
      buf_wr     <= '0;
      buf_rd     <= 1'b0;
      ee_req     <= '0;
      cmd_strobe <= 1'b0;
      command_code_bits <= 6'h00;
      ee_rd_block <= 7'h00;
      for (int i = 0; i < reg_count; i++)
        regs[i] <= reg_reset_value;
    end
    else
    begin
      buf_wr.valid <= 1'b0;
      buf_rd       <= 1'b0;
      ee_req.valid <= 1'b0;
      cmd_strobe   <= 1'b0;
      if (!enabled || stop_cond)
      begin
        state    <= st_idle;                                 // [RL3]
        sda_oe_n <= 1'b1;
      end
      else if (start_cond)
      begin
        // mode and pointer survive a repeated start for the read phase
        state    <= st_addr;
        bit_cnt  <= 3'h0;
        byte_idx <= 3'h0;
        is_read  <= 1'b0;
        sda_oe_n <= 1'b1;
      end
      else
      begin
        case (state)
          st_addr, st_rx:
            if (scl_rise)
            begin
              shreg   <= rx_byte;
              bit_cnt <= bit_cnt + 3'h1;
              if (byte_done)
                state <= st_rxack;
            end
          st_rxack:
            if (scl_fall)
            begin
              // acknowledge the byte just received; bad writes still ack [RL16]
              if (byte_idx == 3'h0 && !addr_hit)
                state <= st_skip;
              else
              begin
                sda_oe_n <= 1'b0;
                state    <= st_txack;
              end
            end
          st_txack:
            if (scl_fall)
            begin
              // ack phase ended: commit the byte and pick the next direction
              sda_oe_n <= 1'b1;
              bit_cnt  <= 3'h0;
              state    <= st_rx;
              if (is_read)
              begin
                tx_byte  <= next_tx;
                sda_oe_n <= next_tx[7];                       // [RL13]
                state    <= st_tx;
              end
              else if (byte_idx == 3'h0)
              begin
                is_read <= shreg[0];
                if (shreg[0])
                begin
                  tx_byte  <= next_tx;
                  sda_oe_n <= next_tx[7];                     // [RL12]
                  state    <= st_tx;
                end
                else
                  byte_idx <= 3'h1;
              end
              else if (byte_idx == 3'h1)
              begin
                mode     <= shreg[7:6];                       // [RL5] [RL17]
                ptr      <= {2'h0, shreg[4:0]};
                ee_byte  <= 2'h0;
                byte_idx <= 3'h2;
                if (!mode_ok)
                  state <= st_skip;                           // [RL6]
                else if (shreg[7:6] == mode_command)
                begin
                  cmd_strobe        <= 1'b1;
                  command_code_bits <= shreg[5:0];
                end
              end
              else
              begin
                byte_idx <= 3'h3;
                case (mode)
                  mode_reg:
                  begin
                    if (reg_ok)
                      regs[ptr[4:0]] <= shreg;                // [RL10] [RL16]
                    ptr <= ptr + 7'h1;                        // [RL11]
                  end
                  mode_buffer:
                    buf_wr <= '{valid: 1'b1, mode: mode, addr: ptr, data: shreg};
                  mode_eeprom:
                    if (byte_idx == 3'h2)
                    begin
                      ptr         <= shreg[7:1];              // [RL20]
                      ee_rd_block <= shreg[7:1];
                    end
                    else
                    begin
                      ee_data <= {ee_data[23:0], shreg};      // [RL19]
                      ee_byte <= ee_byte + 2'h1;
                      if (ee_byte == 2'(ee_bytes_last))
                      begin
                        ee_req   <= '{valid: 1'b1, block: ptr,
                                      data: {ee_data[23:0], shreg}};
                        state    <= st_skip;
                      end
                    end
                  default:
                    state <= st_skip;
                endcase
              end
            end
          st_tx:
            if (scl_fall)
            begin
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7)
              begin
                sda_oe_n <= 1'b1;
                state    <= st_rxack;
                shreg    <= 8'h00;
              end
              else
              begin
                tx_byte  <= {tx_byte[6:0], 1'b0};
                sda_oe_n <= tx_byte[6];
              end
            end
          default:
            sda_oe_n <= 1'b1;
        endcase
        // master ack after a read byte: advance now, reload at the next clock fall
        if (state == st_rxack && is_read && scl_rise)
        begin
          if (sda)
            state <= st_skip;
          else
          begin
            case (mode)
              mode_reg:    ptr <= ptr + 7'h1;                 // [RL13]
              mode_buffer: buf_rd <= 1'b1;
              mode_eeprom:
              begin
                ee_byte <= ee_byte + 2'h1;
                if (ee_byte == 2'(ee_bytes_last))
                  ee_rd_block <= ee_rd_block + 7'h1;
              end
              default: ;
            endcase
            state <= st_txack;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= irq_pending;                                    // [RL15]
  end
endmodule : tag_i2c_slave_host_port
`default_nettype wire

// >>> core/tag_i2c_pkg.sv
// constants and carrier types of the tag two-wire host port
// Operation
// [RL1] act only as target, single master bus
// [RL2] accept standard, fast and fast-plus rates
// [RL3] port enabled only while select low
// [RL4] host holds select low through transaction
// [RL5] registers, eeprom, buffer and direct commands
// [RL6] interface supply: only register and eeprom; the port still allows buffer and command reads after a repeated start
// [RL7] address 1010 plus three programmable bits
// [RL8] low address bits from config byte
// [RL9] host sends address, register, data msb first
// [RL10] commit byte at its last bit; the port commits when the ack clock falls
// [RL11] write increments register address per byte
// [RL12] read returns bytes msb first
// [RL13] read increments register address per byte
// [RL14] unimplemented register reads as zero
// [RL15] interrupt output high when pending
// [RL16] bad write acknowledged, changes nothing
// [RL17] buffer mode 10b, read sets ones
// [RL18] command answer 01h accepted, 02h rejected
// [RL19] eeprom write: block plus four bytes
// [RL20] block address is upper seven bits
package tag_i2c_pkg;
  localparam logic [3:0] addr_fixed_bits  = 4'ha;
  localparam int         addr_low_lsb     = 0;
  localparam logic [7:0] cmd_ok_answer    = 8'h01;
  localparam logic [7:0] cmd_reject_answer = 8'h02;
  localparam logic [1:0] mode_reg         = 2'h0;
  localparam logic [1:0] mode_eeprom      = 2'h1;
  localparam logic [1:0] mode_buffer      = 2'h2;
  localparam logic [1:0] mode_command     = 2'h3;
  localparam logic [5:0] buf_read_code    = 6'h3f;
  localparam logic [5:0] ee_read_code     = 6'h3f;
  localparam logic [2:0] ee_bytes_last    = 3'h3;
  localparam int         reg_count        = 32;
  localparam logic [7:0] reg_reset_value  = 8'h00;
  localparam logic [2:0] sync_init        = 3'h7;

  typedef enum logic [2:0] {
    st_idle  = 3'b000,
    st_addr  = 3'b001,
    st_rx    = 3'b010,
    st_rxack = 3'b011,
    st_tx    = 3'b100,
    st_txack = 3'b101,
    st_skip  = 3'b110
  } bus_state_type;

  // one write toward the buffer
  typedef struct packed {
    logic       valid;
    logic [1:0] mode;
    logic [6:0] addr;
    logic [7:0] data;
  } write_type;

  // one eeprom block program request
  typedef struct packed {
    logic        valid;
    logic [6:0]  block;
    logic [31:0] data;
  } ee_req_type;
endpackage : tag_i2c_pkg

// >>> core/pin_sync.sv
// three-stage synchroniser with filtered level
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import tag_i2c_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // pin and filtered level
  input  wire logic pin,
  output logic      level
);
  logic [2:0] stage;

  // a change counts once the last two stages agree
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      stage <= sync_init;
      level <= 1'b1;
    end
    else
    begin
      stage <= {stage[1:0], pin};
      if (stage[1] == stage[2])
        level <= stage[2];
    end
  end
endmodule : pin_sync
`default_nettype wire

// >>> tb/tag_i2c_host_model.sv
// bus master model: select, clock and data of the host
`timescale 1ns/1ps
`default_nettype none
module tag_i2c_host_model #(parameter int Q = 50)
(
  // clock
  input  wire logic core_clk,
  // bus
  output logic      select_n,
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  initial
  begin
    select_n = 1'b1;
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // a quarter of the bit time; Q=50 gives a 1 us bit
  task automatic q;
    repeat (Q) @(negedge core_clk);
  endtask : q
  task automatic start(input logic en);
    if (en) select_n = 1'b0;
    sda_drv = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_drv = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask : start
  task automatic stop;
    sda_drv = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_drv = 1'b1;
    q();
    select_n = 1'b1;
    // idle gap so the port sees select high between transfers
    q();
  endtask : stop
  // data moves only while clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask : bit_io
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wr
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : rd
endmodule : tag_i2c_host_model
`default_nettype wire

// >>> tb/tag_i2c_slave_host_port_sva.sv
// concurrent checks on the host port pins
`timescale 1ns/1ps
`default_nettype none
module tag_i2c_port_checker
  import tag_i2c_pkg::*;
(
  // clock and reset
  input wire logic       core_clk,
  input wire logic       srst,
  // pins and sideband
  input wire logic       select_n,
  input wire logic       scl_in,
  input wire logic       sda_oe_n,
  input wire logic       interface_supply_pin,
  input wire logic       irq_pending,
  input wire logic       irq,
  input wire write_type  buf_wr,
  input wire logic       buf_rd,
  input wire ee_req_type ee_req,
  input wire logic       cmd_strobe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  chk_idle_release: assert property (select_n [*8] |-> sda_oe_n)
    else $error("data line held while deselected");
  chk_idle_quiet: assert property (select_n [*8] |-> !(cmd_strobe || buf_rd || buf_wr.valid))
    else $error("strobe while deselected");
  chk_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data line moved with clock high");
  chk_irq_rise: assert property (irq_pending |-> ##[1:4] irq)
    else $error("interrupt line not raised");
  chk_irq_fall: assert property (!irq_pending [*4] |-> !irq)
    else $error("interrupt line stuck high");
  chk_supply_block: assert property (interface_supply_pin |-> !(buf_wr.valid || buf_rd || cmd_strobe))
    else $error("buffer or command under interface supply");
  chk_cmd_pulse: assert property (cmd_strobe |=> !cmd_strobe)
    else $error("command strobe too long");
  chk_buf_mode: assert property (buf_wr.valid |-> buf_wr.mode == mode_buffer && !$past(buf_wr.valid))
    else $error("bad buffer write");
  chk_ee_pulse: assert property (ee_req.valid |=> !ee_req.valid)
    else $error("program request too long");
  chk_reset_quiet: assert property ($fell(srst) |-> sda_oe_n && !irq && !cmd_strobe)
    else $error("outputs active after reset");
endmodule : tag_i2c_port_checker
bind tag_i2c_slave_host_port tag_i2c_port_checker u_chk (.core_clk, .srst, .select_n, .scl_in,
  .sda_oe_n, .interface_supply_pin, .irq_pending, .irq, .buf_wr, .buf_rd, .ee_req, .cmd_strobe);
`default_nettype wire

// >>> tb/tag_i2c_slave_host_port_test.sv
// self-checking bench of the tag two-wire host port
`timescale 1ns/1ps
`default_nettype none
module tag_i2c_slave_host_port_test import tag_i2c_pkg::*;;
  logic        core_clk, srst, sel_n, scl, sda_drv, supply, irq_pending, cmd_reject;
  logic        sda_oe_n, irq, buf_rd, cmd_strobe, ak;
  logic [7:0]  cfg, buf_rdata, lb;
  logic [5:0]  code, lc;
  logic [6:0]  ee_rd_block;
  logic [31:0] ee_rdata;
  write_type   buf_wr;
  ee_req_type  ee_req, le;
  logic [7:0]  wd[8], rb[8];
  int          n_fail, tests_run, nb, nc, n_rd;
  // pull-up: line is low only while someone pulls it
  wire         sda = sda_drv & sda_oe_n;
  localparam logic [6:0] dev = {addr_fixed_bits, 3'h5};
  tag_i2c_host_model u_host (.core_clk, .select_n(sel_n), .scl, .sda_drv, .sda);
  tag_i2c_slave_host_port u_dut (.core_clk, .srst, .select_n(sel_n), .scl_in(scl),
    .sda_in(sda), .sda_oe_n, .nv_config_byte_zero(cfg), .interface_supply_pin(supply),
    .irq_pending, .irq, .buf_wr, .buf_rd, .buf_rdata, .ee_req, .ee_rd_block, .ee_rdata,
    .cmd_strobe, .command_code_bits(code), .cmd_reject);
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // strobes caught away from the launching edge
  always @(negedge core_clk)
  begin
    if (buf_wr.valid === 1'b1)
    begin
      nb++;
      lb = buf_wr.data;
    end
    if (cmd_strobe === 1'b1)
    begin
      nc++;
      lc = code;
    end
    if (ee_req.valid === 1'b1) le = ee_req;
    if (buf_rd === 1'b1) n_rd++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d errors %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // address, mode byte, nw bytes out, then repeated start and nr bytes back
  task automatic xfer(input logic [6:0] a, input logic [7:0] m, input int nw, input int nr);
    logic x;
    u_host.start(1'b1);
    u_host.wr({a, 1'b0}, ak);
    u_host.wr(m, x);
    for (int i = 0; i < nw; i++) u_host.wr(wd[i], x);
    if (nr > 0)
    begin
      u_host.start(1'b1);
      u_host.wr({a, 1'b1}, x);
      for (int i = 0; i < nr; i++) u_host.rd(i == nr - 1, rb[i]);
    end
    u_host.stop();
  endtask : xfer
  task automatic t_regs;
    wd = '{8'h5a, 8'ha5, 8'h3c, 0, 0, 0, 0, 0};
    xfer(dev, {mode_reg, 6'h1d}, 3, 0);
    chk(ak, 1'b1);
    xfer(dev, {mode_reg, 6'h1d}, 0, 4);
    chk(rb[3], 8'h00);
    for (int i = 0; i < 3; i++) chk(rb[i], wd[i]);
  endtask : t_regs
  task automatic t_addr;
    cfg = 8'h02;
    u_host.start(1'b1);
    u_host.wr({dev, 1'b0}, ak);
    u_host.stop();
    chk(ak, 1'b0);
    u_host.start(1'b1);
    u_host.wr({addr_fixed_bits, 3'h2, 1'b0}, ak);
    u_host.stop();
    chk(ak, 1'b1);
    cfg = 8'h05;
    u_host.start(1'b0);
    u_host.wr({dev, 1'b0}, ak);
    u_host.stop();
    chk(ak, 1'b0);
  endtask : t_addr
  task automatic t_cmd;
    int c0;
    for (int r = 0; r < 2; r++)
    begin
      cmd_reject = r[0];
      c0 = nc;
      xfer(dev, {mode_command, 6'h15}, 0, 1);
      chk(nc - c0, 1);
      chk(lc, 6'h15);
      chk(rb[0], r ? cmd_reject_answer : cmd_ok_answer);
    end
  endtask : t_cmd
  task automatic t_buf;
    int b0;
    int c0;
    wd[0] = 8'h11;
    wd[1] = 8'h22;
    b0 = nb;
    xfer(dev, {mode_buffer, 6'h00}, 2, 0);
    chk(nb - b0, 2);
    chk(lb, 8'h22);
    c0 = n_rd;
    xfer(dev, {mode_buffer, buf_read_code}, 0, 2);
    chk(rb[0], buf_rdata);
    chk(rb[1], buf_rdata);
    chk(n_rd - c0, 1);
    supply = 1'b1;
    b0 = nb;
    c0 = nc;
    xfer(dev, {mode_buffer, 6'h00}, 1, 0);
    xfer(dev, {mode_command, 6'h15}, 0, 0);
    chk(nb - b0, 0);
    chk(nc - c0, 0);
    supply = 1'b0;
  endtask : t_buf
  task automatic t_ee;
    wd = '{8'h15, 8'h01, 8'h23, 8'h45, 8'h67, 0, 0, 0};
    le = '0;
    xfer(dev, {mode_eeprom, 6'h00}, 5, 0);
    chk(le.valid, 1'b1);
    chk(le.block, 7'h0a);
    chk(le.data, 32'h01234567);
    ee_rdata = 32'h89abcdef;
    xfer(dev, {mode_eeprom, ee_read_code}, 1, 2);
    chk(ee_rd_block, 7'h0a);
    chk(rb[0], ee_rdata[31:24]);
    chk(rb[1], ee_rdata[23:16]);
  endtask : t_ee
  task automatic t_irq;
    irq_pending = 1'b1;
    repeat (6) @(negedge core_clk);
    chk(irq, 1'b1);
    irq_pending = 1'b0;
    repeat (6) @(negedge core_clk);
    chk(irq, 1'b0);
  endtask : t_irq
  initial
  begin
    srst = 1'b1;
    supply = 1'b0;
    irq_pending = 1'b0;
    cmd_reject = 1'b0;
    cfg = 8'h05;
    buf_rdata = 8'h6e;
    ee_rdata = 32'h0;
    repeat (16) @(negedge core_clk);
    srst = 1'b0;
    repeat (8) @(negedge core_clk);
    t_regs();
    t_addr();
    t_cmd();
    t_buf();
    t_ee();
    t_irq();
    conclude();
  end
  // whole run is near 96k cycles
  initial
  begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    conclude();
  end
endmodule : tag_i2c_slave_host_port_test
`default_nettype wire
